// ==== hw/fsdm_defs.svh ====
// Offsets, field positions, reset values and limits of the station data mapper
`ifndef FSDM_DEFS_SVH
`define FSDM_DEFS_SVH
// Register byte offsets
`define FSDM_OFF_CTRL      12'h000
`define FSDM_OFF_CFGSIZE   12'h004
`define FSDM_OFF_STATUS    12'h008
`define FSDM_OFF_IRQ_STAT  12'h00C
`define FSDM_OFF_IRQ_CLR   12'h010
`define FSDM_OFF_IRQ_EN    12'h014
// Control register fields
`define FSDM_CTRL_V2       0
`define FSDM_CTRL_PLC      1
`define FSDM_CTRL_MODE     2
`define FSDM_CTRL_STN_LSB  4
`define FSDM_CTRL_EXT_LSB  8
`define FSDM_CTRL_RESET    32'h0000_0003
`define FSDM_CTRL_MASK     32'h0000_0337
// Status register fields
`define FSDM_ST_BIT_LSB    8
`define FSDM_ST_WORD_LSB   16
`define FSDM_ST_CFGERR     28
`define FSDM_ST_ERR        29
`define FSDM_ST_READY      30
// Interrupt bits
`define FSDM_IRQ_W         3
`define FSDM_IRQ_CFGERR    0
`define FSDM_IRQ_ERRSET    1
`define FSDM_IRQ_ERRCLR    2
// System area flag positions, output byte 0
`define FSDM_OB_INIT_DONE  0
`define FSDM_OB_SET_REQ    1
`define FSDM_OB_ERR_RST    2
`define FSDM_OB_MASK       8'h07
// System area flag positions, input byte 0
`define FSDM_IB_INIT_REQ   0
`define FSDM_IB_SET_DONE   1
`define FSDM_IB_ERR        2
`define FSDM_IB_READY      3
// Control and status word bit disabled under the controller profile
`define FSDM_CW_DIS_BIT    13
// Version 1 configuration size limits per station count
`define FSDM_V1_MAX1       9'h00C
`define FSDM_V1_MAX2       9'h018
`define FSDM_V1_MAX3       9'h024
`define FSDM_V1_MAX4       9'h030
// Bytes of bit data reserved for the system area
`define FSDM_SYS_BYTES     10'h002
`endif

// ==== hw/fsdm_pkg.sv ====
// Types shared by the station data mapper
package fsdm_pkg;
  // Controller profile handshake states
  typedef enum logic [2:0]
  {
    FSDM_INIT  = 3'b001,
    FSDM_RUN   = 3'b010,
    FSDM_SETUP = 3'b100
  } fsdm_plc_state_type;
  // Subnetwork protocol mode
  typedef enum logic
  {
    FSDM_QUERY   = 1'b0,
    FSDM_PRODUCE = 1'b1
  } fsdm_subnet_type;
endpackage : fsdm_pkg

// ==== hw/fsdm_size_calc.sv ====
// Station count and bit/word data sizing from the fieldbus settings
`timescale 1ns/1ns
`default_nettype none
`include "fsdm_defs.svh"
module fsdm_size_calc
(
  // Settings
  input  wire logic       version2_en,
  input  wire logic [1:0] station_cfg,
  input  wire logic [1:0] ext_code,
  input  wire logic [8:0] cfg_size,
  // Results
  output logic      [2:0] stations,
  output logic      [7:0] bit_bytes,
  output logic      [8:0] word_bytes,
  output logic            size_err
);
  // Bit data bytes for n stations; extension cycles 2..8 scale 8n-4
  function automatic logic [7:0] fsdm_bit_size(input logic [2:0] n, input logic [1:0] code);
    logic [7:0] base;
    base = {2'h0, n, 3'h0} - 8'h04;
    case (code)
      2'h0:    fsdm_bit_size = {3'h0, n, 2'h0};
      2'h1:    fsdm_bit_size = base;
      2'h2:    fsdm_bit_size = {base[6:0], 1'b0};
      default: fsdm_bit_size = {base[5:0], 2'h0};
    endcase
  endfunction : fsdm_bit_size

  // Word data bytes: eight per station per extension cycle
  function automatic logic [8:0] fsdm_word_size(input logic [2:0] n, input logic [1:0] code);
    fsdm_word_size = {3'h0, n, 3'h0} << code;
  endfunction : fsdm_word_size

  logic [9:0] usable;

  // Version 1 takes stations from the real configuration size
  always_comb
  begin
    if (version2_en)
      stations = {1'b0, station_cfg} + 3'h1;
    else if (cfg_size <= `FSDM_V1_MAX1)
      stations = 3'h1;
    else if (cfg_size <= `FSDM_V1_MAX2)
      stations = 3'h2;
    else if (cfg_size <= `FSDM_V1_MAX3)
      stations = 3'h3;
    else
      stations = 3'h4;
  end

  // Version 1 always runs one cycle; version 2 uses the extension code
  assign bit_bytes  = fsdm_bit_size(stations, version2_en ? ext_code : 2'h0);
  assign word_bytes = fsdm_word_size(stations, version2_en ? ext_code : 2'h0);
  // Two bytes of bit data belong to the system area, not to user data
  assign usable = {2'h0, bit_bytes} + {1'b0, word_bytes} - `FSDM_SYS_BYTES;
  // Oversized configuration cannot be served by these settings
  assign size_err = version2_en ? ({1'b0, cfg_size} > usable)
                                : (cfg_size > `FSDM_V1_MAX4);
endmodule : fsdm_size_calc
`default_nettype wire

// ==== hw/fsdm_mapper.sv ====
// Fieldbus station data mapper: sizing, system area flags, error status, APB registers
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "fsdm_defs.svh"
// How it works
// - Version 1: up to 12/24/36/48 configuration bytes gives 1/2/3/4 stations.
// - Version 1: each station adds 4 bit-data bytes and 8 word-data bytes.
// - Version 2: size from 1-4 stations and 1/2/4/8 extension cycles, up to 112/256.
// - Settings that cannot hold the configuration are refused and reported as error.
// - Last 16 bits of bit data carry flags, never user data.
// - Controller profile makes and eats flags; profile off passes system area unchanged except the error flag toward the master.
// - Transparent mode: only the error status flag is driven by the block.
// - Controller profile clears bit 13 of control and status words.
// - Output byte 0 holds three master flags; its other bits are masked off.
// - Output byte 1 ignored; input byte 1 zero under the controller profile, passed from the buffer with it off.
// - Input byte 0 carries four flags under the controller profile; other bits zero.
// - Fatal event sets error status for good; only reset clears it.
// - Query mode: error while slaves missing, cleared once all answer.
// - Producer mode: error on consume timeout, cleared after recovery.
// - Producer mode: error on invalid message, cleared after recovery.
// - Version 2 off: run version 1 with stations from actual configuration size.
// - Two bytes each way of the internal areas go to the system area.
module fsdm_mapper
  import fsdm_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // System area from the master and toward the memory buffer
  input  wire logic [15:0]       fb_out_sys,
  output logic      [15:0]       sub_out_sys,
  // System area from the memory buffer and toward the master
  input  wire logic [15:0]       sub_in_sys,
  output logic      [15:0]       fb_in_sys,
  // Control and status words
  input  wire logic [15:0]       ctrl_word_in,
  output logic      [15:0]       ctrl_word_eff,
  input  wire logic [15:0]       status_word_in,
  output logic      [15:0]       status_word_eff,
  // Subnetwork fault reports
  input  wire logic              fatal_evt,
  input  wire logic              slaves_missing,
  input  wire logic              consume_timeout,
  input  wire logic              invalid_msg,
  input  wire logic              msg_recovered,
  // Sizing results
  output logic      [2:0]        occupied_stations,
  output logic      [7:0]        bit_data_bytes,
  output logic      [8:0]        word_data_bytes,
  output logic                   link_run,
  // Interrupt
  output logic                   irq
);
  generate
    if (ADDR_W < 5 || ADDR_W > 32)
    begin : g_bad_addr
      $error("fsdm_mapper: ADDR_W must lie between 5 and 32");
    end
  endgenerate

  logic [31:0]              ctrl;
  logic [8:0]               cfg_size;
  logic [`FSDM_IRQ_W-1:0]   irq_stat;
  logic [`FSDM_IRQ_W-1:0]   irq_en;
  logic [`FSDM_IRQ_W-1:0]   next_irq_stat;
  logic [`FSDM_IRQ_W-1:0]   irq_evt;
  logic [11:0]              addr;
  logic                     wr_acc;
  logic                     hit;
  logic [31:0]              rd_mux;
  logic                     plc;
  logic                     version2_en;
  fsdm_subnet_type          subnet_mode;
  logic [2:0]               calc_stations;
  logic [7:0]               calc_bits;
  logic [8:0]               calc_words;
  logic                     calc_err;
  logic                     calc_err_q;
  logic                     fatal_latch;
  logic                     invalid_latch;
  logic                     err_status;
  logic                     err_q;
  logic [7:0]               ob0;
  logic                     err_rst_q;
  fsdm_plc_state_type       plc_state;
  fsdm_plc_state_type       next_plc_state;
  logic                     remote_ready;

  // Bus decode; upper address bits beyond the map are ignored
  assign addr   = 12'(paddr);
  assign wr_acc = psel && penable && pwrite;
  assign hit    = (addr == `FSDM_OFF_CTRL) || (addr == `FSDM_OFF_CFGSIZE)
               || (addr == `FSDM_OFF_STATUS) || (addr == `FSDM_OFF_IRQ_STAT)
               || (addr == `FSDM_OFF_IRQ_CLR) || (addr == `FSDM_OFF_IRQ_EN);
  // Zero wait states: read data is loaded in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // Setting fields
  assign version2_en = ctrl[`FSDM_CTRL_V2];
  assign plc         = ctrl[`FSDM_CTRL_PLC];
  assign subnet_mode = fsdm_subnet_type'(ctrl[`FSDM_CTRL_MODE]);

  // Control and configuration size registers
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl     <= `FSDM_CTRL_RESET;
      cfg_size <= 9'h000;
    end
    else if (wr_acc && addr == `FSDM_OFF_CTRL)
      ctrl <= pwdata & `FSDM_CTRL_MASK;
    else if (wr_acc && addr == `FSDM_OFF_CFGSIZE)
      cfg_size <= pwdata[8:0];
  end

  // Interrupt enable register
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_en <= '0;
    else if (wr_acc && addr == `FSDM_OFF_IRQ_EN)
      irq_en <= pwdata[`FSDM_IRQ_W-1:0];
  end

  // Read mux; write-only clear register reads zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (addr)
      `FSDM_OFF_CTRL:     rd_mux = ctrl;
      `FSDM_OFF_CFGSIZE:  rd_mux = {23'h000000, cfg_size};
      `FSDM_OFF_STATUS:
      begin
        rd_mux[2:0]                                 = occupied_stations;
        rd_mux[`FSDM_ST_BIT_LSB+7:`FSDM_ST_BIT_LSB]   = bit_data_bytes;
        rd_mux[`FSDM_ST_WORD_LSB+8:`FSDM_ST_WORD_LSB] = word_data_bytes;
        rd_mux[`FSDM_ST_CFGERR]                     = calc_err_q;
        rd_mux[`FSDM_ST_ERR]                        = err_status;
        rd_mux[`FSDM_ST_READY]                      = remote_ready;
      end
      `FSDM_OFF_IRQ_STAT: rd_mux[`FSDM_IRQ_W-1:0] = irq_stat;
      `FSDM_OFF_IRQ_EN:   rd_mux[`FSDM_IRQ_W-1:0] = irq_en;
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data register
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

  // Sizing arithmetic
  fsdm_size_calc u_size
  (
    .version2_en (version2_en),
    .station_cfg (ctrl[`FSDM_CTRL_STN_LSB+1:`FSDM_CTRL_STN_LSB]),
    .ext_code    (ctrl[`FSDM_CTRL_EXT_LSB+1:`FSDM_CTRL_EXT_LSB]),
    .cfg_size    (cfg_size),
    .stations    (calc_stations),
    .bit_bytes   (calc_bits),
    .word_bytes  (calc_words),
    .size_err    (calc_err)
  );

  // Only settings that fit are taken; refused ones leave the old sizes and stop the link
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      occupied_stations <= 3'h1;
      bit_data_bytes    <= 8'h04;
      word_data_bytes   <= 9'h008;
      calc_err_q        <= 1'b0;
    end
    else
    begin
      calc_err_q <= calc_err;
      if (!calc_err)
      begin
        occupied_stations <= calc_stations;
        bit_data_bytes    <= calc_bits;
        word_data_bytes   <= calc_words;
      end
    end
  end
  assign link_run = !calc_err_q;

  // Fatal latch: only reset clears it
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      fatal_latch <= 1'b0;
    else if (fatal_evt)
      fatal_latch <= 1'b1;
  end

  // Invalid message latch; a new message wins over a same-cycle recovery
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      invalid_latch <= 1'b0;
    else if (invalid_msg)
      invalid_latch <= 1'b1;
    else if (msg_recovered)
      invalid_latch <= 1'b0;
  end

  // Error status: level sources clear themselves once the condition recovers
  assign err_status = fatal_latch || fatal_evt
                   || (subnet_mode == FSDM_QUERY && slaves_missing)
                   || (subnet_mode == FSDM_PRODUCE && consume_timeout)
                   || (subnet_mode == FSDM_PRODUCE && (invalid_latch || invalid_msg));

  // Master flags: byte 1 and unused bits of byte 0 are never looked at
  assign ob0 = fb_out_sys[7:0] & `FSDM_OB_MASK;

  // Error reset request edge detector
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      err_rst_q <= 1'b0;
    else
      err_rst_q <= ob0[`FSDM_OB_ERR_RST];
  end

  // Profile handshake: request initial processing, then serve setting requests
  always_comb
  begin
    next_plc_state = plc_state;
    case (plc_state)
      FSDM_INIT:  if (ob0[`FSDM_OB_INIT_DONE]) next_plc_state = FSDM_RUN;
      FSDM_RUN:   if (ob0[`FSDM_OB_SET_REQ]) next_plc_state = FSDM_SETUP;
      FSDM_SETUP: if (!ob0[`FSDM_OB_SET_REQ]) next_plc_state = FSDM_RUN;
      default:    next_plc_state = FSDM_INIT;
    endcase
  end

  // Handshake state; restarts when the profile is off so a later switch-on begins clean
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      plc_state <= FSDM_INIT;
    else if (!plc)
      plc_state <= FSDM_INIT;
    else
      plc_state <= next_plc_state;
  end
  // An error reset request does not lift the ready flag while a fault stands
  assign remote_ready = (plc_state != FSDM_INIT) && !err_status && link_run;

  // System area toward the master
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      fb_in_sys <= 16'h0000;
    else if (plc)
    begin
      fb_in_sys                    <= 16'h0000;
      fb_in_sys[`FSDM_IB_INIT_REQ] <= (plc_state == FSDM_INIT);
      fb_in_sys[`FSDM_IB_SET_DONE] <= (plc_state == FSDM_SETUP);
      fb_in_sys[`FSDM_IB_ERR]      <= err_status;
      fb_in_sys[`FSDM_IB_READY]    <= remote_ready;
    end
    else
    begin
      fb_in_sys              <= sub_in_sys;
      fb_in_sys[`FSDM_IB_ERR] <= err_status;
    end
  end

  // System area toward the buffer: flags consumed under the profile, passed through unchanged with it off
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      sub_out_sys <= 16'h0000;
    else if (plc)
      sub_out_sys <= 16'h0000;
    else
      sub_out_sys <= fb_out_sys;
  end

  // Control and status words with the profile bit disabled
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_word_eff   <= 16'h0000;
      status_word_eff <= 16'h0000;
    end
    else
    begin
      ctrl_word_eff                      <= ctrl_word_in;
      status_word_eff                    <= status_word_in;
      ctrl_word_eff[`FSDM_CW_DIS_BIT]    <= ctrl_word_in[`FSDM_CW_DIS_BIT] && !plc;
      status_word_eff[`FSDM_CW_DIS_BIT]  <= status_word_in[`FSDM_CW_DIS_BIT] && !plc;
    end
  end

  // Interrupt events and sticky status; an event beats a same-cycle clear
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      err_q <= 1'b0;
    else
      err_q <= err_status;
  end
  assign irq_evt[`FSDM_IRQ_CFGERR] = calc_err && !calc_err_q;
  assign irq_evt[`FSDM_IRQ_ERRSET] = err_status && !err_q;
  assign irq_evt[`FSDM_IRQ_ERRCLR] = !err_status && err_q;
  always_comb
  begin
    next_irq_stat = irq_stat;
    if (wr_acc && addr == `FSDM_OFF_IRQ_CLR)
      next_irq_stat = irq_stat & ~pwdata[`FSDM_IRQ_W-1:0];
    next_irq_stat = next_irq_stat | irq_evt;
  end
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_stat <= '0;
    else
      irq_stat <= next_irq_stat;
  end
  assign irq = |(irq_stat & irq_en);

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  v1_small_a: assert property (!version2_en && cfg_size <= `FSDM_V1_MAX1
    |=> occupied_stations == 3'h1) else $error("one station expected");
  v1_large_a: assert property (!version2_en && cfg_size > `FSDM_V1_MAX3
    && !calc_err |=> occupied_stations == 3'h4) else $error("four stations expected");
  v1_sizes_a: assert property (!version2_en && !calc_err
    |=> bit_data_bytes == {3'h0, occupied_stations, 2'h0}
     && word_data_bytes == {3'h0, occupied_stations, 3'h0}) else $error("v1 sizes wrong");
  v2_max_a: assert property (version2_en && ctrl[5:4] == 2'h3 && ctrl[9:8] == 2'h3
    && !calc_err |=> bit_data_bytes == 8'h70 && word_data_bytes == 9'h100)
    else $error("largest v2 size wrong");
  reject_hold_a: assert property (calc_err |=> !link_run && $stable(bit_data_bytes)
    && $stable(word_data_bytes)) else $error("refused settings were taken");
  sys_reserve_a: assert property (plc |=> sub_out_sys == 16'h0000)
    else $error("user data in system area");
  pass_thru_a: assert property (!plc |=> sub_out_sys == $past(fb_out_sys))
    else $error("system area not passed through");
  transp_err_a: assert property (!plc |=> fb_in_sys[`FSDM_IB_ERR] == $past(err_status)
    && fb_in_sys[1:0] == $past(sub_in_sys[1:0])) else $error("transparent byte wrong");
  bit13_off_a: assert property (plc |=> !ctrl_word_eff[13] && !status_word_eff[13])
    else $error("bit 13 not disabled");
  plc_bytes_a: assert property (plc |=> fb_in_sys[15:4] == 12'h000
    && fb_in_sys[`FSDM_IB_ERR] == $past(err_status)) else $error("input system byte wrong");
  fatal_hold_a: assert property (fatal_evt |=> err_status [*8])
    else $error("fatal error status dropped");
  slaves_err_a: assert property (subnet_mode == FSDM_QUERY && slaves_missing
    |-> err_status ##1 (fb_in_sys[`FSDM_IB_ERR])) else $error("missing slaves not flagged");
  timeout_err_a: assert property (subnet_mode == FSDM_PRODUCE && consume_timeout
    |-> err_status) else $error("consume timeout not flagged");
  invalid_err_a: assert property (subnet_mode == FSDM_PRODUCE && invalid_msg
    ##1 (subnet_mode == FSDM_PRODUCE && !msg_recovered) |-> err_status)
    else $error("invalid message not held");
endmodule : fsdm_mapper
`default_nettype wire

// ==== tb/fsdm_master_model.sv ====
// Fieldbus master model driving the output system area
`timescale 1ns/1ns
`default_nettype none
module fsdm_master_model
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Requests from the bench
  input  wire logic        set_req,
  input  wire logic        err_rst,
  // System area
  input  wire logic [15:0] fb_in_sys,
  output logic      [15:0] fb_out_sys
);
  logic        done;
  logic [12:0] noise;
  // Acknowledge the init request and keep it up
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      done <= 1'b0;
    else if (fb_in_sys[0])
      done <= 1'b1;
  // Reserved bits churn every cycle so a design that reads them shows it
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      noise <= 13'h1A5A;
    else
      noise <= noise + 13'h0B37;
  // Byte 1 and bits 7:3 of byte 0 are junk
  assign fb_out_sys = {noise, err_rst, set_req, done};
endmodule : fsdm_master_model
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the station data mapper
`timescale 1ns/1ns
`default_nettype none
`include "fsdm_defs.svh"
module tb;
  typedef struct {logic [31:0] ctrl, cfg, stn, bitb, wordb;} fsdm_row_type;
  logic        mclk, sys_rst, psel, penable, pwrite, pready, pslverr, serr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] fb_out_sys, sub_out_sys, sub_in_sys, fb_in_sys, prev;
  logic [15:0] cw_in, cw_eff, sw_in, sw_eff;
  logic        fatal_evt, slaves_missing, consume_timeout, invalid_msg, msg_recovered;
  logic        set_req, err_rst, link_run, irq;
  logic [2:0]  stn;
  logic [7:0]  bitb;
  logic [8:0]  wordb;
  int          fails, n_tests, cycles;
  // Settings beside the sizes they give
  fsdm_row_type rows [8] = '{
    '{32'h333, 32'h00A, 32'h4, 32'h70, 32'h100}, '{32'h003, 32'h00A, 32'h1, 32'h04, 32'h008},
    '{32'h113, 32'h00A, 32'h2, 32'h0C, 32'h020}, '{32'h223, 32'h00A, 32'h3, 32'h28, 32'h060},
    '{32'h002, 32'h00C, 32'h1, 32'h04, 32'h008}, '{32'h002, 32'h00D, 32'h2, 32'h08, 32'h010},
    '{32'h002, 32'h024, 32'h3, 32'h0C, 32'h018}, '{32'h002, 32'h030, 32'h4, 32'h10, 32'h020}};
  fsdm_mapper dut
  (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fb_out_sys(fb_out_sys), .sub_out_sys(sub_out_sys), .sub_in_sys(sub_in_sys),
    .fb_in_sys(fb_in_sys), .ctrl_word_in(cw_in), .ctrl_word_eff(cw_eff),
    .status_word_in(sw_in), .status_word_eff(sw_eff), .fatal_evt(fatal_evt),
    .slaves_missing(slaves_missing), .consume_timeout(consume_timeout),
    .invalid_msg(invalid_msg), .msg_recovered(msg_recovered), .occupied_stations(stn),
    .bit_data_bytes(bitb), .word_data_bytes(wordb), .link_run(link_run), .irq(irq)
  );
  fsdm_master_model master
  (
    .mclk(mclk), .sys_rst(sys_rst), .set_req(set_req), .err_rst(err_rst),
    .fb_in_sys(fb_in_sys), .fb_out_sys(fb_out_sys)
  );
  // Clock
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Hang guard, far above the two hundred or so cycles the tests take
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      summarize();
    end
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One APB transfer; waits on pready, never a fixed count
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Let the flags settle, then compare the input system area
  task automatic sa(input logic [15:0] msk, input logic [15:0] exp);
    repeat (3) @(posedge mclk);
    chk("fb_in_sys", 32'(fb_in_sys & msk), 32'(exp));
  endtask : sa
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, set_req, err_rst} = '0;
    {fatal_evt, slaves_missing, consume_timeout, invalid_msg, msg_recovered} = '0;
    sub_in_sys = 16'h1234;
    cw_in = 16'hFFFF;
    sw_in = 16'hFFFF;
    sys_rst = 1'b1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    chk("stations", 32'(stn), 32'h1);
    chk("bit_bytes", 32'(bitb), 32'h4);
    chk("word_bytes", 32'(wordb), 32'h8);
    apb(1'b0, `FSDM_OFF_CTRL, 32'h0);
    chk("ctrl", rd, `FSDM_CTRL_RESET);
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, `FSDM_OFF_CTRL, rows[i].ctrl);
      apb(1'b1, `FSDM_OFF_CFGSIZE, rows[i].cfg);
      repeat (2) @(posedge mclk);
      apb(1'b0, `FSDM_OFF_STATUS, 32'h0);
      chk("stations", 32'(stn), rows[i].stn);
      chk("bit_bytes", 32'(bitb), rows[i].bitb);
      chk("word_bytes", 32'(wordb), rows[i].wordb);
      chk("status", rd & 32'h01FF_FF07, (rows[i].wordb << 16) | (rows[i].bitb << 8) | rows[i].stn);
    end
    $display("sizing table done");
    // Refused settings keep the old sizes and raise the interrupt
    apb(1'b1, `FSDM_OFF_IRQ_EN, 32'h7);
    apb(1'b1, `FSDM_OFF_CFGSIZE, 32'h31);
    repeat (2) @(posedge mclk);
    chk("link_run", 32'(link_run), 32'h0);
    chk("stations", 32'(stn), 32'h4);
    chk("irq", 32'(irq), 32'h1);
    apb(1'b1, `FSDM_OFF_IRQ_CLR, 32'h1);
    @(negedge mclk);
    chk("irq", 32'(irq), 32'h0);
    apb(1'b1, `FSDM_OFF_IRQ_EN, 32'h0);
    // A fitting large setting first, so the next refusal is a fresh event
    apb(1'b1, `FSDM_OFF_CTRL, 32'h333);
    apb(1'b1, `FSDM_OFF_CTRL, 32'h003);
    apb(1'b1, `FSDM_OFF_CFGSIZE, 32'h00B);
    repeat (2) @(posedge mclk);
    apb(1'b0, `FSDM_OFF_STATUS, 32'h0);
    chk("cfg_refused", 32'(rd[`FSDM_ST_CFGERR]), 32'h1);
    chk("bit_bytes", 32'(bitb), 32'h70);
    chk("irq", 32'(irq), 32'h0);
    apb(1'b1, `FSDM_OFF_IRQ_EN, 32'h1);
    @(negedge mclk);
    chk("irq", 32'(irq), 32'h1);
    apb(1'b1, `FSDM_OFF_IRQ_CLR, 32'h1);
    apb(1'b1, `FSDM_OFF_CFGSIZE, 32'h00A);
    repeat (2) @(posedge mclk);
    chk("link_run", 32'(link_run), 32'h1);
    chk("bit_bytes", 32'(bitb), 32'h4);
    apb(1'b0, 12'h020, 32'h0);
    chk("pslverr", 32'(serr), 32'h1);
    chk("unmapped", rd, 32'h0);
    $display("refusal test done");
    // Controller profile flags and error sources
    sa(16'hFFFF, 16'h0008);
    chk("ctrl_word", 32'(cw_eff), 32'hDFFF);
    chk("status_word", 32'(sw_eff), 32'hDFFF);
    chk("sub_out_sys", 32'(sub_out_sys), 32'h0);
    set_req <= 1'b1;
    sa(16'hFFF2, 16'h0002);
    set_req <= 1'b0;
    slaves_missing <= 1'b1;
    sa(16'hFFFF, 16'h0004);
    slaves_missing <= 1'b0;
    sa(16'hFFFF, 16'h0008);
    apb(1'b1, `FSDM_OFF_CTRL, 32'h007);
    slaves_missing <= 1'b1;
    consume_timeout <= 1'b1;
    sa(16'hFFFF, 16'h0004);
    consume_timeout <= 1'b0;
    sa(16'hFFFF, 16'h0008);
    slaves_missing <= 1'b0;
    invalid_msg <= 1'b1;
    @(posedge mclk);
    invalid_msg <= 1'b0;
    sa(16'hFFFF, 16'h0004);
    msg_recovered <= 1'b1;
    @(posedge mclk);
    msg_recovered <= 1'b0;
    sa(16'hFFFF, 16'h0008);
    // Error set and error clear events both seen, no new refusal
    apb(1'b0, `FSDM_OFF_IRQ_STAT, 32'h0);
    chk("irq_stat", rd, 32'h6);
    $display("profile test done");
    // Transparent system area, then a fatal event
    apb(1'b1, `FSDM_OFF_CTRL, 32'h005);
    sa(16'hFFFF, 16'h1230);
    chk("ctrl_word", 32'(cw_eff), 32'hFFFF);
    @(negedge mclk);
    prev = fb_out_sys;
    @(negedge mclk);
    chk("sub_out_sys", 32'(sub_out_sys), 32'(prev));
    @(posedge mclk);
    fatal_evt <= 1'b1;
    @(posedge mclk);
    fatal_evt <= 1'b0;
    err_rst <= 1'b1;
    sa(16'hFFFF, 16'h1234);
    apb(1'b1, `FSDM_OFF_CTRL, 32'h007);
    sa(16'h000C, 16'h0004);
    $display("transparent test done");
    // Only a reset clears the fatal latch
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    err_rst <= 1'b0;
    sa(16'h0004, 16'h0000);
    $display("second reset test done");
    summarize();
  end
endmodule : tb
`default_nettype wire
